//--- common/csc_cfg.svh
`ifndef CSC_CFG_SVH
`define CSC_CFG_SVH
// instruction word fields (bit 0 is the msb of a 36-bit word)
`define CSC_OP_IO_LO 9'o700
`define CSC_OP_IO_HI 9'o777
`define CSC_OP_CTL0 9'o700
`define CSC_OP_CTL1 9'o701
`define CSC_OP_CTL2 9'o702
// accumulator field extensions, opcode 700
`define CSC_AC_RD_ID 4'h0
`define CSC_AC_WR_CPU 4'h4
`define CSC_AC_RD_CPU 4'h5
`define CSC_AC_WR_INT 4'hc
`define CSC_AC_RD_INT 4'hd
// accumulator field extensions, opcode 701
`define CSC_AC_RD_UB 4'h1
`define CSC_AC_CLR_PG 4'h2
`define CSC_AC_LD_UB 4'h3
`define CSC_AC_LD_EB 4'h4
`define CSC_AC_RD_EB 4'h5
// cpu control word bit positions (msb-0 numbering)
`define CSC_CC_EN 20
`define CSC_CC_DIS 21
`define CSC_CC_CLR 22
`define CSC_CC_SET 23
`define CSC_CC_CON 25
`define CSC_CC_SEL 26
`define CSC_CC_REQ 32
`define CSC_CC_LVL 33
`define CSC_ST_EN 8
// interrupt control word bit positions
`define CSC_IC_DROP 22
`define CSC_IC_CLRSYS 23
`define CSC_IC_REQ 24
`define CSC_IC_CHON 25
`define CSC_IC_CHOFF 26
`define CSC_IC_SYSOFF 27
`define CSC_IC_SYSON 28
`define CSC_IC_SEL 29
// user base word
`define CSC_UB_LDAC 0
`define CSC_UB_LDBASE 2
`define CSC_UB_CUR 6
`define CSC_UB_PRV 9
`define CSC_UB_BASE_W 11
// exec base word
`define CSC_EB_PAGING 21
`define CSC_EB_TRAP 22
`define CSC_EB_BASE_W 11
// page fail codes
`define CSC_PF_NXIO 6'o20
`define CSC_PF_PARITY 6'o25
`define CSC_PF_HARD 6'o36
`define CSC_PF_NXM 6'o37
// executive table slots
`define CSC_EPT_PI_BASE 9'o040
`define CSC_EPT_VEC_BASE 9'o100
`endif

//--- common/csc_pkg.sv
package csc_pkg;
	typedef logic [0:35] csc_word_t;
	typedef enum logic [2:0] {
		CSC_OP_NONE,
		CSC_OP_WR,
		CSC_OP_RD
	} csc_kind_t;
	// condition index: 5 power, 4 nxm, 3 hard, 2 soft, 1 timer, 0 console
	typedef logic [5:0] csc_cond_t;
	typedef logic [1:7] csc_chan_t;
endpackage : csc_pkg

//--- common/csc_pi_if.sv
`timescale 1ns/1ns
interface csc_pi_if;
	import csc_pkg::*;
	logic wr;
	logic [0:35] wdata;
	logic cpu_req;
	logic [2:0] cpu_lvl;
	csc_chan_t prog_req;
	csc_chan_t hold;
	csc_chan_t chan_on;
	logic sys_on;
	logic grant;
	logic [2:0] grant_chan;
	logic ack;
	modport ctl (output wr, output wdata, output cpu_req, output cpu_lvl, output ack,
		input prog_req, input hold, input chan_on, input sys_on, input grant, input grant_chan);
	modport pi (input wr, input wdata, input cpu_req, input cpu_lvl, input ack,
		output prog_req, output hold, output chan_on, output sys_on, output grant,
		output grant_chan);
endinterface : csc_pi_if

//--- design/csc_sync.sv
`timescale 1ns/1ns
module csc_sync #(
	parameter int W = 1
) (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic [W-1:0] din,
	output logic [W-1:0] rise
);
	logic [W-1:0] s1_ff, s2_ff, s3_ff, nxt_s1, nxt_s2, nxt_s3;
	logic [W-1:0] rise_seen_ff;
	logic [W-1:0] nxt_seen;
	// refuse an empty synchroniser
	if (W < 1) begin : g_bad_w
		$error("W out of range");
	end
	// three stages; rise counts once stage two and three agree
	always_comb begin
		nxt_s1 = din;
		nxt_s2 = s1_ff;
		nxt_s3 = s2_ff;
	end
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			s1_ff <= '0;
			s2_ff <= '0;
			s3_ff <= '0;
		end else begin
			s1_ff <= nxt_s1;
			s2_ff <= nxt_s2;
			s3_ff <= nxt_s3;
		end
	end
	assign rise = s2_ff & s3_ff & ~rise_seen_ff;
	// remember agreed level so each rise is one pulse
	always_comb begin
		nxt_seen = rise_seen_ff;
		for (int i = 0; i < W; i++) begin
			if (s2_ff[i] == s3_ff[i]) begin
				nxt_seen[i] = s3_ff[i];
			end
		end
	end
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			rise_seen_ff <= '0;
		end else begin
			rise_seen_ff <= nxt_seen;
		end
	end
endmodule : csc_sync

//--- design/csc_pi.sv
`timescale 1ns/1ns
`include "csc_cfg.svh"
module csc_pi
	import csc_pkg::*;
(
	input wire logic mclk,
	input wire logic nrst,
	csc_pi_if.pi bus
);
	csc_chan_t req_ff, hold_ff, on_ff, nxt_req, nxt_hold, nxt_on;
	logic sys_ff, nxt_sys;
	csc_chan_t sel, cpu_ch, pend, dis;
	logic [2:0] best;
	logic found;
	logic grant_c;
	// -------------------------------------------------------------
	// priority interrupt system
	// -------------------------------------------------------------
	always_comb begin
		sel = bus.wdata[`CSC_IC_SEL +: 7];
		cpu_ch = '0;
		dis = '0;
		if (bus.cpu_req && bus.cpu_lvl != 3'h0) begin
			cpu_ch[bus.cpu_lvl] = 1'b1;
		end
		nxt_req = req_ff;
		nxt_hold = hold_ff;
		nxt_on = on_ff;
		nxt_sys = sys_ff;
		if (bus.wr) begin
			if (bus.wdata[`CSC_IC_DROP]) nxt_req = nxt_req & ~sel;
			if (bus.wdata[`CSC_IC_REQ]) nxt_req = nxt_req | sel;
			if (bus.wdata[`CSC_IC_CHON]) nxt_on = nxt_on | sel;
			if (bus.wdata[`CSC_IC_CHOFF]) nxt_on = nxt_on & ~sel;
			if (bus.wdata[`CSC_IC_SYSON]) nxt_sys = 1'b1;
			if (bus.wdata[`CSC_IC_SYSOFF]) nxt_sys = 1'b0;
			if (bus.wdata[`CSC_IC_CLRSYS]) begin
				nxt_req = '0;
				nxt_hold = '0;
				nxt_on = '0;
				nxt_sys = 1'b0;
			end
		end
		// dismiss clears the highest holding channel
		if (bus.ack) begin
			for (int i = 7; i >= 1; i--) begin
				if (hold_ff[i]) dis = csc_chan_t'(1) << (7 - i);
			end
		end
		nxt_hold = nxt_hold & ~dis;
		// grant moves the winning channel into holding; set wins over dismiss
		if (grant_c) begin
			nxt_hold[best] = 1'b1;
			nxt_req[best] = 1'b0;
		end
	end
	// highest active channel above any holding one
	always_comb begin
		pend = (req_ff | cpu_ch) & on_ff;
		best = 3'h0;
		found = 1'b0;
		for (int i = 7; i >= 1; i--) begin
			if (pend[i]) begin
				best = 3'(i);
				found = 1'b1;
			end
			if (hold_ff[i] && (3'(i) <= best || !found)) begin
				found = found && (best < 3'(i));
			end
		end
		grant_c = sys_ff && found;
	end
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			req_ff <= '0;
			hold_ff <= '0;
			on_ff <= '0;
			sys_ff <= 1'b0;
		end else begin
			req_ff <= nxt_req;
			hold_ff <= nxt_hold;
			on_ff <= nxt_on;
			sys_ff <= nxt_sys;
		end
	end
	assign bus.prog_req = req_ff;
	assign bus.hold = hold_ff;
	assign bus.chan_on = on_ff;
	assign bus.sys_on = sys_ff;
	assign bus.grant = grant_c;
	assign bus.grant_chan = best;
endmodule : csc_pi

//--- design/csc_top.sv
`timescale 1ns/1ns
`include "csc_cfg.svh"
module csc_top
	import csc_pkg::*;
#(
	parameter int PAGE_W = 9
) (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic exec_valid,
	input wire logic [0:35] exec_instr,
	input wire logic [0:35] exec_operand,
	output logic exec_done,
	output logic exec_store,
	output logic [0:35] exec_result,
	output logic exec_illegal,
	input wire logic mem_nxm,
	input wire logic mem_hard,
	input wire logic mem_soft,
	input wire logic mem_from_cpu,
	input wire logic mem_pf_parity,
	input wire logic io_nxdev,
	input wire logic [0:35] io_addr,
	input wire logic timer_done,
	input wire logic power_fail,
	input wire logic console_to_cpu_interrupt,
	output logic cpu_to_console_interrupt,
	output logic page_fail_trap,
	output logic [0:35] page_fail_word,
	output logic periph_nxm,
	output logic page_clear,
	output logic [PAGE_W-1:0] page_clear_vpn,
	output logic [0:2] cur_ac_block,
	output logic [0:2] prev_ac_block,
	output logic [`CSC_UB_BASE_W-1:0] user_base_page,
	output logic [`CSC_EB_BASE_W-1:0] exec_base_page,
	output logic exec_paging,
	output logic exec_trap_en,
	output logic int_request,
	output logic [2:0] int_channel,
	output logic [8:0] int_slot,
	output logic [8:0] int_vector_slot,
	input wire logic int_taken,
	input wire logic int_dismiss
);
	// refuse page widths the operand field cannot hold
	if (PAGE_W < 1 || PAGE_W > 18) begin : g_bad_page_w
		$error("PAGE_W out of range");
	end
	csc_pi_if pib();
	csc_pi csc_pi_inst (.mclk(mclk), .nrst(nrst), .bus(pib));
	// -------------------------------------------------------------
	// asynchronous condition inputs
	// -------------------------------------------------------------
	logic [1:0] pin_rise;
	csc_sync #(.W(2)) csc_sync_inst (
		.mclk(mclk),
		.nrst(nrst),
		.din({power_fail, console_to_cpu_interrupt}),
		.rise(pin_rise)
	);
	// -------------------------------------------------------------
	// decode
	// -------------------------------------------------------------
	logic [8:0] opc;
	logic [3:0] acf;
	logic is_io, wr_cpu, rd_cpu, wr_int, rd_int, rd_ub, ld_ub, clr_pg, ld_eb, rd_eb, rd_id;
	always_comb begin
		opc = exec_instr[0:8];
		acf = exec_instr[9:12];
		is_io = opc >= `CSC_OP_IO_LO && opc <= `CSC_OP_IO_HI;
		rd_id = exec_valid && is_io && opc == `CSC_OP_CTL0 && acf == `CSC_AC_RD_ID;
		wr_cpu = exec_valid && is_io && opc == `CSC_OP_CTL0 && acf == `CSC_AC_WR_CPU;
		rd_cpu = exec_valid && is_io && opc == `CSC_OP_CTL0 && acf == `CSC_AC_RD_CPU;
		wr_int = exec_valid && is_io && opc == `CSC_OP_CTL0 && acf == `CSC_AC_WR_INT;
		rd_int = exec_valid && is_io && opc == `CSC_OP_CTL0 && acf == `CSC_AC_RD_INT;
		rd_ub = exec_valid && is_io && opc == `CSC_OP_CTL1 && acf == `CSC_AC_RD_UB;
		clr_pg = exec_valid && is_io && opc == `CSC_OP_CTL1 && acf == `CSC_AC_CLR_PG;
		ld_ub = exec_valid && is_io && opc == `CSC_OP_CTL1 && acf == `CSC_AC_LD_UB;
		ld_eb = exec_valid && is_io && opc == `CSC_OP_CTL1 && acf == `CSC_AC_LD_EB;
		rd_eb = exec_valid && is_io && opc == `CSC_OP_CTL1 && acf == `CSC_AC_RD_EB;
	end
	// -------------------------------------------------------------
	// condition flags, enables, level
	// -------------------------------------------------------------
	csc_cond_t flag_ff, en_ff, nxt_flag, nxt_en, sel, hw_set;
	logic preq_ff, nxt_preq, con_ff, nxt_con;
	logic [2:0] lvl_ff, nxt_lvl;
	always_comb begin
		sel = exec_operand[`CSC_CC_SEL +: 6];
		hw_set = {pin_rise[1], mem_nxm & mem_from_cpu, mem_hard, mem_soft,
			timer_done, pin_rise[0]};
		nxt_flag = flag_ff;
		nxt_en = en_ff;
		nxt_preq = preq_ff;
		nxt_lvl = lvl_ff;
		nxt_con = 1'b0;
		if (wr_cpu) begin
			if (exec_operand[`CSC_CC_EN]) nxt_en = nxt_en | sel;
			if (exec_operand[`CSC_CC_DIS]) nxt_en = nxt_en & ~sel;
			if (exec_operand[`CSC_CC_CLR]) nxt_flag = nxt_flag & ~sel;
			if (exec_operand[`CSC_CC_SET]) nxt_flag = nxt_flag | sel;
			nxt_con = exec_operand[`CSC_CC_CON];
			nxt_preq = exec_operand[`CSC_CC_REQ];
			nxt_lvl = exec_operand[`CSC_CC_LVL +: 3];
		end
		nxt_flag = nxt_flag | hw_set; // hardware set wins over clear
	end
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			flag_ff <= '0;
			en_ff <= '0;
			preq_ff <= 1'b0;
			lvl_ff <= 3'h0;
			con_ff <= 1'b0;
		end else begin
			flag_ff <= nxt_flag;
			en_ff <= nxt_en;
			preq_ff <= nxt_preq;
			lvl_ff <= nxt_lvl;
			con_ff <= nxt_con;
		end
	end
	assign cpu_to_console_interrupt = con_ff;
	// request toward the interrupt system on the assigned level
	assign pib.cpu_req = |(flag_ff & en_ff) || preq_ff;
	assign pib.cpu_lvl = lvl_ff;
	assign pib.wr = wr_int;
	assign pib.wdata = exec_operand;
	assign pib.ack = int_dismiss;
	// -------------------------------------------------------------
	// page fail
	// -------------------------------------------------------------
	logic pf_ff, nxt_pf, pnxm_ff, nxt_pnxm;
	logic [0:35] pfw_ff, nxt_pfw;
	always_comb begin
		nxt_pf = 1'b0;
		nxt_pfw = pfw_ff;
		nxt_pnxm = mem_nxm && !mem_from_cpu;
		if (mem_from_cpu && (mem_nxm || mem_hard)) begin
			nxt_pf = 1'b1;
			nxt_pfw = '0;
			nxt_pfw[1] = 1'b1;
			nxt_pfw[0:5] = mem_nxm ? `CSC_PF_NXM : `CSC_PF_HARD;
		end else if (mem_pf_parity) begin
			nxt_pf = 1'b1;
			nxt_pfw = '0;
			nxt_pfw[1] = 1'b1;
			nxt_pfw[0:5] = `CSC_PF_PARITY;
		end else if (io_nxdev) begin
			nxt_pf = 1'b1;
			nxt_pfw = '0;
			nxt_pfw[1] = 1'b1;
			nxt_pfw[0:5] = `CSC_PF_NXIO;
			nxt_pfw[14:35] = io_addr[14:35];
		end
	end
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			pf_ff <= 1'b0;
			pfw_ff <= '0;
			pnxm_ff <= 1'b0;
		end else begin
			pf_ff <= nxt_pf;
			pfw_ff <= nxt_pfw;
			pnxm_ff <= nxt_pnxm;
		end
	end
	assign page_fail_trap = pf_ff;
	assign page_fail_word = pfw_ff;
	assign periph_nxm = pnxm_ff;
	// -------------------------------------------------------------
	// user base, exec base, page clear
	// -------------------------------------------------------------
	logic [0:2] cur_ff, prv_ff, nxt_cur, nxt_prv;
	logic [`CSC_UB_BASE_W-1:0] ub_ff, nxt_ub, eb_ff, nxt_eb;
	logic pgm_ff, nxt_pgm, trp_ff, nxt_trp, pc_ff, nxt_pc;
	logic [PAGE_W-1:0] vpn_ff, nxt_vpn;
	always_comb begin
		nxt_cur = cur_ff;
		nxt_prv = prv_ff;
		nxt_ub = ub_ff;
		nxt_eb = eb_ff;
		nxt_pgm = pgm_ff;
		nxt_trp = trp_ff;
		nxt_pc = clr_pg;
		nxt_vpn = clr_pg ? exec_operand[27-PAGE_W +: PAGE_W] : vpn_ff;
		if (ld_ub && exec_operand[`CSC_UB_LDAC]) begin
			nxt_cur = exec_operand[`CSC_UB_CUR +: 3];
			nxt_prv = exec_operand[`CSC_UB_PRV +: 3];
		end
		if (ld_ub && exec_operand[`CSC_UB_LDBASE]) begin
			nxt_ub = exec_operand[36-`CSC_UB_BASE_W +: `CSC_UB_BASE_W];
		end
		if (ld_eb) begin
			nxt_eb = exec_operand[36-`CSC_EB_BASE_W +: `CSC_EB_BASE_W];
			nxt_pgm = exec_operand[`CSC_EB_PAGING];
			nxt_trp = exec_operand[`CSC_EB_TRAP];
		end
	end
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			cur_ff <= 3'h0;
			prv_ff <= 3'h0;
			ub_ff <= '0;
			eb_ff <= '0;
			pgm_ff <= 1'b0;
			trp_ff <= 1'b0;
			pc_ff <= 1'b0;
			vpn_ff <= '0;
		end else begin
			cur_ff <= nxt_cur;
			prv_ff <= nxt_prv;
			ub_ff <= nxt_ub;
			eb_ff <= nxt_eb;
			pgm_ff <= nxt_pgm;
			trp_ff <= nxt_trp;
			pc_ff <= nxt_pc;
			vpn_ff <= nxt_vpn;
		end
	end
	assign cur_ac_block = cur_ff;
	assign prev_ac_block = prv_ff;
	assign user_base_page = ub_ff;
	assign exec_base_page = eb_ff;
	assign exec_paging = pgm_ff;
	assign exec_trap_en = trp_ff;
	assign page_clear = pc_ff;
	assign page_clear_vpn = vpn_ff;
	// -------------------------------------------------------------
	// interrupt fetch slots
	// -------------------------------------------------------------
	logic [8:0] slot_ff, vslot_ff, nxt_slot, nxt_vslot;
	always_comb begin
		nxt_slot = slot_ff;
		nxt_vslot = vslot_ff;
		if (pib.grant) begin
			nxt_slot = `CSC_EPT_PI_BASE + {5'h0, pib.grant_chan, 1'b0};
			nxt_vslot = `CSC_EPT_VEC_BASE + {5'h0, pib.grant_chan, 1'b0};
		end
	end
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			slot_ff <= '0;
			vslot_ff <= '0;
		end else begin
			slot_ff <= nxt_slot;
			vslot_ff <= nxt_vslot;
		end
	end
	assign int_request = pib.grant && !int_taken;
	assign int_channel = pib.grant_chan;
	assign int_slot = slot_ff;
	assign int_vector_slot = vslot_ff;
	// -------------------------------------------------------------
	// answer to the execution path
	// -------------------------------------------------------------
	logic done_ff, st_ff, ill_ff, nxt_done, nxt_st, nxt_ill;
	logic [0:35] res_ff, nxt_res;
	always_comb begin
		nxt_done = exec_valid;
		nxt_st = 1'b0;
		nxt_ill = exec_valid && !(rd_id || wr_cpu || rd_cpu || wr_int || rd_int || rd_ub
			|| ld_ub || clr_pg || ld_eb || rd_eb);
		nxt_res = res_ff;
		if (rd_cpu) begin
			nxt_st = 1'b1;
			nxt_res = '0;
			nxt_res[`CSC_ST_EN +: 6] = en_ff;
			nxt_res[`CSC_CC_SEL +: 6] = flag_ff;
			nxt_res[`CSC_CC_REQ] = preq_ff;
			nxt_res[`CSC_CC_LVL +: 3] = lvl_ff;
		end else if (rd_int) begin
			nxt_st = 1'b1;
			nxt_res = '0;
			nxt_res[11:17] = pib.prog_req;
			nxt_res[21:27] = pib.hold;
			nxt_res[28] = pib.sys_on;
			nxt_res[29:35] = pib.chan_on;
		end else if (rd_ub) begin
			nxt_st = 1'b1;
			nxt_res = '0;
			nxt_res[`CSC_UB_LDAC] = 1'b1;
			nxt_res[`CSC_UB_LDBASE] = 1'b1;
			nxt_res[`CSC_UB_CUR +: 3] = cur_ff;
			nxt_res[`CSC_UB_PRV +: 3] = prv_ff;
			nxt_res[36-`CSC_UB_BASE_W +: `CSC_UB_BASE_W] = ub_ff;
		end else if (rd_eb) begin
			nxt_st = 1'b1;
			nxt_res = '0;
			nxt_res[`CSC_EB_PAGING] = pgm_ff;
			nxt_res[`CSC_EB_TRAP] = trp_ff;
			nxt_res[36-`CSC_EB_BASE_W +: `CSC_EB_BASE_W] = eb_ff;
		end else if (rd_id) begin
			nxt_st = 1'b1;
			nxt_res = '0;
		end
	end
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			done_ff <= 1'b0;
			st_ff <= 1'b0;
			ill_ff <= 1'b0;
			res_ff <= '0;
		end else begin
			done_ff <= nxt_done;
			st_ff <= nxt_st;
			ill_ff <= nxt_ill;
			res_ff <= nxt_res;
		end
	end
	assign exec_done = done_ff;
	assign exec_store = st_ff;
	assign exec_result = res_ff;
	assign exec_illegal = ill_ff;
endmodule : csc_top

//--- dv/csc_top_monitor.sv
`timescale 1ns/1ns
`include "csc_cfg.svh"
module csc_top_monitor
	import csc_pkg::*;
#(
	parameter int PAGE_W = 9
) (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic exec_valid,
	input wire logic [0:35] exec_instr,
	input wire logic [0:35] exec_operand,
	input wire logic exec_done,
	input wire logic exec_store,
	input wire logic [0:35] exec_result,
	input wire logic exec_illegal,
	input wire logic mem_nxm,
	input wire logic mem_from_cpu,
	input wire logic cpu_to_console_interrupt,
	input wire logic page_fail_trap,
	input wire logic [0:35] page_fail_word,
	input wire logic periph_nxm,
	input wire logic page_clear,
	input wire logic [PAGE_W-1:0] page_clear_vpn,
	input wire logic [0:2] cur_ac_block,
	input wire logic [0:2] prev_ac_block
);
	logic [0:12] opac;
	logic nxt_rd_ub;
	logic rd_ub_ff;
	logic [PAGE_W-1:0] nxt_vpn;
	logic [PAGE_W-1:0] vpn_ff;
	// ------------------------------
	// request memory
	// ------------------------------
	// opcode and ac field of the request
	assign opac = exec_instr[0:12];
	// user base read and page to clear
	always_comb begin
		nxt_rd_ub = nrst && exec_valid && opac == {`CSC_OP_CTL1, `CSC_AC_RD_UB};
		nxt_vpn = exec_operand[18 +: PAGE_W];
	end
	always_ff @(posedge mclk) begin
		rd_ub_ff <= nxt_rd_ub;
		vpn_ff <= nxt_vpn;
	end
	// ------------------------------
	// checks
	// ------------------------------
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!nrst);
	a_done_one_cycle: assert property (exec_valid |=> exec_done)
		else $error("no done after request");
	a_io_class_refused: assert property (exec_valid && exec_instr[0:8] == 9'h1c8
		|=> exec_illegal && !exec_store) else $error("opcode 710 not refused");
	a_console_pulse: assert property (exec_valid && exec_operand[`CSC_CC_CON]
		&& opac == {`CSC_OP_CTL0, `CSC_AC_WR_CPU} |=> cpu_to_console_interrupt)
		else $error("no console interrupt");
	a_ub_read_ones: assert property (rd_ub_ff
		|-> exec_store && exec_result[0] && exec_result[2]) else $error("bits 0 2 not set");
	a_ac_load_gate: assert property (exec_valid && !exec_operand[0]
		&& opac == {`CSC_OP_CTL1, `CSC_AC_LD_UB}
		|=> $stable(cur_ac_block) && $stable(prev_ac_block)) else $error("ac block loaded");
	a_page_clear_pulse: assert property (exec_valid
		&& opac == {`CSC_OP_CTL1, `CSC_AC_CLR_PG} |=> page_clear && page_clear_vpn == vpn_ff)
		else $error("page clear wrong");
	a_cpu_nxm_trap: assert property (mem_nxm && mem_from_cpu
		|-> ##[1:2] page_fail_trap && page_fail_word[0:5] == `CSC_PF_NXM)
		else $error("no nxm page fail");
	a_periph_nxm: assert property (mem_nxm && !mem_from_cpu |-> ##[1:2] periph_nxm)
		else $error("no peripheral nxm");
	a_periph_no_trap: assert property (mem_nxm && !mem_from_cpu
		|=> !page_fail_trap ##1 !page_fail_trap) else $error("trap on peripheral nxm");
endmodule : csc_top_monitor

bind csc_top csc_top_monitor #(.PAGE_W(PAGE_W)) csc_top_monitor_inst (.mclk, .nrst,
	.exec_valid, .exec_instr, .exec_operand, .exec_done, .exec_store, .exec_result,
	.exec_illegal, .mem_nxm, .mem_from_cpu, .cpu_to_console_interrupt, .page_fail_trap,
	.page_fail_word, .periph_nxm, .page_clear, .page_clear_vpn, .cur_ac_block, .prev_ac_block);

//--- dv/csc_exec_model.sv
`timescale 1ns/1ns
module csc_exec_model (
	input wire logic mclk,
	input wire logic exec_done,
	output logic exec_valid,
	output logic [0:35] exec_instr,
	output logic [0:35] exec_operand
);
	// idle lines at time zero
	initial begin
		exec_valid = 1'b0;
		exec_instr = 36'h0;
		exec_operand = 36'h0;
	end
	// one request held to its taking edge, then released with scrambled data
	task automatic issue(input logic [0:35] ins, input logic [0:35] opd, output bit ok);
		@(posedge mclk);
		exec_valid <= 1'b1;
		exec_instr <= ins;
		exec_operand <= opd;
		@(posedge mclk);
		exec_valid <= 1'b0;
		exec_instr <= ~ins;
		exec_operand <= ~opd;
		ok = 1'b0;
		repeat (4) begin
			#1;
			if (!ok && exec_done === 1'b1) begin
				return;
			end
			@(posedge mclk);
		end
		ok = 1'b1;
	endtask : issue
endmodule : csc_exec_model

//--- dv/csc_top_tb.sv
`timescale 1ns/1ns
`include "csc_cfg.svh"
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin mismatches++; \
	$display("BAD %s exp %h got %h", nm, e, g); end end
module csc_top_tb;
	import csc_pkg::*;
	logic mclk, nrst, exec_valid, exec_done, exec_store, exec_illegal, mem_nxm, mem_hard;
	logic mem_soft, mem_from_cpu, mem_pf_parity, io_nxdev, timer_done, power_fail;
	logic console_to_cpu_interrupt, cpu_to_console_interrupt, page_fail_trap, periph_nxm;
	logic page_clear, exec_paging, exec_trap_en, int_request, int_taken, int_dismiss;
	logic [0:35] exec_instr, exec_operand, exec_result, io_addr, page_fail_word, res, pf;
	logic [8:0] page_clear_vpn, int_slot, int_vector_slot;
	logic [0:2] cur_ac_block, prev_ac_block;
	logic [10:0] user_base_page, exec_base_page;
	logic [2:0] int_channel, chan;
	logic seen_trap, seen_periph, seen_req;
	int mismatches = 0;
	int n_compared = 0;
	csc_top csc_top_inst (.mclk, .nrst, .exec_valid, .exec_instr, .exec_operand, .exec_done,
		.exec_store, .exec_result, .exec_illegal, .mem_nxm, .mem_hard, .mem_soft, .mem_from_cpu,
		.mem_pf_parity, .io_nxdev, .io_addr, .timer_done, .power_fail, .console_to_cpu_interrupt,
		.cpu_to_console_interrupt, .page_fail_trap, .page_fail_word, .periph_nxm, .page_clear,
		.page_clear_vpn, .cur_ac_block, .prev_ac_block, .user_base_page, .exec_base_page,
		.exec_paging, .exec_trap_en, .int_request, .int_channel, .int_slot, .int_vector_slot,
		.int_taken, .int_dismiss);
	csc_exec_model csc_exec_model_inst (.mclk, .exec_done, .exec_valid, .exec_instr,
		.exec_operand);
	// 125 MHz clock
	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end
	task automatic end_of_test();
		if (mismatches == 0 && n_compared > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : end_of_test
	// one instruction through the partner; a hang ends the run
	task automatic op(input logic [0:8] opc, input logic [0:3] ac, input logic [0:35] opd);
		bit ok;
		csc_exec_model_inst.issue({opc, ac, 23'h0}, opd, ok);
		if (ok) begin
			mismatches++;
			end_of_test();
		end
		res = exec_result;
	endtask : op
	// catches one-cycle pulses over n cycles
	task automatic watch(input int n);
		{seen_trap, seen_periph, seen_req} = 3'h0;
		repeat (n) begin
			#1;
			if (page_fail_trap === 1'b1) begin
				seen_trap = 1'b1;
				pf = page_fail_word;
			end
			if (periph_nxm === 1'b1) seen_periph = 1'b1;
			if (int_request === 1'b1 && !seen_req) begin
				seen_req = 1'b1;
				chan = int_channel;
			end
			@(posedge mclk);
		end
	endtask : watch
	task automatic t_illegal();
		op(9'h1c8, 4'h0, 36'h0);
		`CHK("illegal_io", 2'h2, {exec_illegal, exec_store})
		op(`CSC_OP_CTL0, 4'h1, 36'h0);
		`CHK("illegal_ac", 2'h2, {exec_illegal, exec_store})
		op(`CSC_OP_CTL0, `CSC_AC_RD_ID, 36'h0);
		`CHK("id_read", 3'h2, {exec_illegal, exec_store, |res})
	endtask : t_illegal
	task automatic t_errors();
		logic [5:0] code [4];
		code = '{`CSC_PF_NXM, `CSC_PF_HARD, `CSC_PF_PARITY, `CSC_PF_NXIO};
		for (int i = 0; i < 4; i++) begin
			@(posedge mclk);
			{mem_nxm, mem_hard, mem_pf_parity, io_nxdev} <= 4'h8 >> i;
			{mem_from_cpu, io_addr} <= {1'b1, 36'h0_0003_1234};
			@(posedge mclk);
			{mem_nxm, mem_hard, mem_pf_parity, io_nxdev} <= 4'h0;
			watch(4);
			`CHK("pf_code", {1'b1, code[i]}, {seen_trap, pf[0:5]})
		end
		`CHK("pf_io_addr", io_addr[14:35], pf[14:35])
		@(posedge mclk);
		{mem_nxm, mem_from_cpu} <= 2'h2;
		@(posedge mclk);
		mem_nxm <= 1'b0;
		watch(4);
		`CHK("periph", 2'h2, {seen_periph, seen_trap})
		@(posedge mclk);
		{mem_soft, timer_done, power_fail, console_to_cpu_interrupt} <= 4'hf;
		@(posedge mclk);
		{mem_soft, timer_done} <= 2'h0;
		watch(8);
		op(`CSC_OP_CTL0, `CSC_AC_RD_CPU, 36'h0);
		`CHK("hw_flags", 12'h03f, {res[8:13], res[26:31]})
	endtask : t_errors
	task automatic t_cpu();
		op(`CSC_OP_CTL0, `CSC_AC_WR_CPU, 36'h0_0000_97f5);
		op(`CSC_OP_CTL0, `CSC_AC_RD_CPU, 36'h0);
		`CHK("status_all", 36'h0_0fc0_03f5, res)
		op(`CSC_OP_CTL0, `CSC_AC_WR_CPU, 36'h0_0000_4282);
		op(`CSC_OP_CTL0, `CSC_AC_WR_CPU, 36'h0_0000_214a);
		op(`CSC_OP_CTL0, `CSC_AC_RD_CPU, 36'h0);
		`CHK("status_mix", 36'h0_05c0_02ba, res)
	endtask : t_cpu
	task automatic t_pi();
		op(`CSC_OP_CTL0, `CSC_AC_WR_INT, 36'h0_0000_04a1);
		// level 2 cpu request wins as soon as channel 2 and the system turn on
		`CHK("pi_grant", 4'ha, {int_request, int_channel})
		op(`CSC_OP_CTL0, `CSC_AC_WR_INT, 36'h0_0000_0811);
		op(`CSC_OP_CTL0, `CSC_AC_RD_INT, 36'h0);
		`CHK("pi_status", 36'h0_0044_00a1, res & ~36'h0_0000_7f00)
		@(posedge mclk);
		int_taken <= 1'b1;
		@(posedge mclk);
		int_taken <= 1'b0;
		watch(2);
		`CHK("slots", {`CSC_EPT_PI_BASE + 9'h4, `CSC_EPT_VEC_BASE + 9'h4},
			{int_slot, int_vector_slot})
		int_dismiss <= 1'b1;
		@(posedge mclk);
		int_dismiss <= 1'b0;
		op(`CSC_OP_CTL0, `CSC_AC_WR_INT, 36'h0_0000_2211);
		op(`CSC_OP_CTL0, `CSC_AC_RD_INT, 36'h0);
		`CHK("pi_drop", 15'h00a0, {res[11:17], res[28:35]})
		op(`CSC_OP_CTL0, `CSC_AC_WR_INT, 36'h0_0000_1000);
		op(`CSC_OP_CTL0, `CSC_AC_RD_INT, 36'h0);
		`CHK("pi_clear", 36'h0, res)
		watch(2);
		`CHK("pi_idle", 1'b0, seen_req)
	endtask : t_pi
	task automatic t_bases();
		op(`CSC_OP_CTL1, `CSC_AC_LD_UB, {3'b101, 3'h0, 3'h2, 3'h4, 13'h0, 11'h5a3});
		`CHK("ub_both", 17'h0a5a3, {cur_ac_block, prev_ac_block, user_base_page})
		op(`CSC_OP_CTL1, `CSC_AC_LD_UB, {3'b001, 3'h0, 3'h6, 3'h1, 13'h0, 11'h0f0});
		`CHK("ub_base", 17'h0a0f0, {cur_ac_block, prev_ac_block, user_base_page})
		op(`CSC_OP_CTL1, `CSC_AC_LD_UB, {3'b100, 3'h0, 3'h3, 3'h7, 13'h0, 11'h111});
		`CHK("ub_ac", 17'h0f8f0, {cur_ac_block, prev_ac_block, user_base_page})
		op(`CSC_OP_CTL1, `CSC_AC_RD_UB, 36'h0);
		`CHK("ub_read", {12'ha1f, 11'h0f0}, {res[0:11], res[25:35]})
		op(`CSC_OP_CTL1, `CSC_AC_LD_EB, {21'h0, 4'hc, 11'h2c7});
		`CHK("eb_load", 13'h1ac7, {exec_paging, exec_trap_en, exec_base_page})
		op(`CSC_OP_CTL1, `CSC_AC_RD_EB, 36'h0);
		`CHK("eb_read", 13'h1ac7, {res[21:22], res[25:35]})
		op(`CSC_OP_CTL1, `CSC_AC_CLR_PG, {18'h0, 9'h1a5, 9'h0});
		`CHK("page_clear", 10'h3a5, {page_clear, page_clear_vpn})
	endtask : t_bases
	// reset, then each scenario in turn
	initial begin
		{nrst, mem_nxm, mem_hard, mem_soft, mem_from_cpu, mem_pf_parity, io_nxdev} = 7'h0;
		{timer_done, power_fail, console_to_cpu_interrupt, int_taken, int_dismiss} = 5'h0;
		io_addr = 36'h0;
		repeat (16) @(posedge mclk);
		nrst <= 1'b1;
		t_illegal();
		t_errors();
		t_cpu();
		t_pi();
		t_bases();
		end_of_test();
	end
endmodule : csc_top_tb
